// ### design/rr_interval_timer.sv
// r-to-r interval result word and beat event flag
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: the result is 14 bits left justified in a 24-bit word whose 10 low bits read zero.
// R02: the result word holds the time between the two latest R events.
// R03: the counter steps once per lsb period of about 8 ms set by configuration.
// R04: R events come from beat detection on the ECG output data stream.
// R05: each new R event loads the interval into the result and sets the beat flag.
// R06: with clear mode 01 the flag clears when the result word is read.
// R07: with clear mode 00 the flag clears when the status word is read.
// R08: with clear mode 10 the flag clears itself after one full ECG data cycle.
// R09: the host picks self clearing only when the second interrupt pin is a heart-rate indicator.
// R10: in interrupt mode a counter overflow sets the flag and loads 0x3FFF.
// R11: an overflow result is reset once it has been read back.
// R12: the flag clears apart from the result word, by the read the clear mode picks.
// R13: in indicator mode an overflow just wraps, with no flag and no code.
// R14: the counter restarts from zero on each R event after its count is captured.
module rr_interval_timer #(
  parameter int unsigned LSB_CYCLES = rr_interval_pkg::LSB_CYCLES
) (
  input  wire logic        ref_clk,              // 200 MHz clock
  input  wire logic        srst,                 // sync reset, high
  input  wire logic        r_event,              // beat detector R event pulse
  input  wire logic        ecg_data_tick,        // pulse per ECG data cycle
  input  wire logic        lsb_tick_en,          // interval timing base running
  input  wire logic [1:0]  beat_flag_clear_mode, // from interrupt_manage_word
  input  wire logic        value_read,           // pulse: result word read done
  input  wire logic        status_read,          // pulse: status word read done
  output logic [23:0]      rr_interval_value,    // read-only result word
  output logic             beat_event_flag,      // status bit
  output logic             second_interrupt_out_n // active-low beat indicator
);
  localparam int unsigned W = rr_interval_pkg::INTERVAL_BITS;

  rr_count_if #(.W(W)) cnt ();

  rr_interval_counter #(
    .W          (W),
    .LSB_CYCLES (LSB_CYCLES)
  ) u_counter (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .lsb_tick_en (lsb_tick_en),
    .cnt         (cnt)
  );

  // ---------------------------------------------------------------
  // result word and flag
  // ---------------------------------------------------------------
  logic [W-1:0] value_q, value_d;
  logic         ovf_held_q, ovf_held_d;
  logic         flag_q, flag_d;
  logic         int_n_q, int_n_d;
  logic         ind_mode;
  logic         ovf_set;
  logic         flag_set;
  logic         flag_clr;

  // r_event is produced from filtered ECG output samples upstream
  assign cnt.restart = r_event; // R04 R14

  always_comb begin
    ind_mode   = beat_flag_clear_mode[rr_interval_pkg::MODE_IND_BIT];
    ovf_set    = cnt.overflow && !ind_mode && !r_event; // R10 R13
    flag_set   = r_event || ovf_set; // R05 R10
    value_d    = value_q;
    ovf_held_d = ovf_held_q;
    if (r_event) begin
      value_d    = cnt.count; // R02 R05
      ovf_held_d = 1'b0;
    end else if (ovf_set) begin
      value_d    = rr_interval_pkg::OVERFLOW_CODE; // R10
      ovf_held_d = 1'b1;
    end else if (ovf_held_q && value_read) begin
      // lets the host see each later overflow as a fresh 0x3FFF
      value_d    = '0; // R11
      ovf_held_d = 1'b0;
    end
    case (beat_flag_clear_mode)
      rr_interval_pkg::CLR_ON_STATUS: flag_clr = status_read; // R07 R12
      rr_interval_pkg::CLR_ON_VALUE:  flag_clr = value_read;  // R06 R12
      default:                        flag_clr = ecg_data_tick; // R08
    endcase
    // a set in the cycle of a clear wins so no beat is lost
    flag_d  = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_q);
    int_n_d = !flag_d;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      value_q    <= '0;
      ovf_held_q <= 1'b0;
      flag_q     <= 1'b0;
      int_n_q    <= 1'b1;
    end else begin
      value_q    <= value_d;
      ovf_held_q <= ovf_held_d;
      flag_q     <= flag_d;
      int_n_q    <= int_n_d;
    end
  end

  assign rr_interval_value      = {value_q, 10'h000}; // R01
  assign beat_event_flag        = flag_q;
  assign second_interrupt_out_n = int_n_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_low_zero;
    @(posedge ref_clk) disable iff (srst)
      rr_interval_value[9:0] == 10'h000;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low result bits not zero"); // R01

  property p_beat_load;
    @(posedge ref_clk) disable iff (srst)
      r_event |=> beat_event_flag && rr_interval_value[23:10] == $past(cnt.count);
  endproperty
  a_beat_load: assert property (p_beat_load) else $error("R event did not load result"); // R05

  property p_restart;
    @(posedge ref_clk) disable iff (srst)
      r_event |=> cnt.count == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted"); // R14

  property p_clr_value;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode == 2'h1 && value_read && !flag_set |=> !beat_event_flag;
  endproperty
  a_clr_value: assert property (p_clr_value) else $error("flag kept after result read"); // R06

  property p_clr_status;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode == 2'h0 && status_read && !flag_set |=> !beat_event_flag;
  endproperty
  a_clr_status: assert property (p_clr_status) else $error("flag kept after status read"); // R07

  property p_clr_self;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode[1] && ecg_data_tick && !flag_set |=> !beat_event_flag;
  endproperty
  a_clr_self: assert property (p_clr_self) else $error("flag did not self clear"); // R08

  property p_clr_apart;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode == 2'h0 && beat_event_flag && value_read && !status_read
      |=> beat_event_flag;
  endproperty
  a_clr_apart: assert property (p_clr_apart) else $error("result read cleared flag"); // R12

  property p_ovf_int;
    @(posedge ref_clk) disable iff (srst)
      cnt.overflow && !beat_flag_clear_mode[1] && !r_event
      |=> beat_event_flag && rr_interval_value == 24'hFFFC00;
  endproperty
  a_ovf_int: assert property (p_ovf_int) else $error("overflow code not loaded"); // R10

  property p_ovf_read;
    @(posedge ref_clk) disable iff (srst)
      ovf_held_q && value_read && !r_event && !ovf_set |=> rr_interval_value == 24'h000000;
  endproperty
  a_ovf_read: assert property (p_ovf_read) else $error("overflow result not reset"); // R11

  property p_ovf_ind;
    @(posedge ref_clk) disable iff (srst)
      cnt.overflow && beat_flag_clear_mode[1] && !r_event && !beat_event_flag
      && !(ovf_held_q && value_read)
      |=> !beat_event_flag && $stable(rr_interval_value);
  endproperty
  a_ovf_ind: assert property (p_ovf_ind) else $error("indicator overflow touched state"); // R13

  property p_pin_follow;
    @(posedge ref_clk) disable iff (srst)
      second_interrupt_out_n == !beat_event_flag;
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("indicator pin out of step"); // R05

  // ---------------------------------------------------------------
  // checks: reset, result hold and counter
  // ---------------------------------------------------------------
  property p_reset_state;
    @(posedge ref_clk)
      srst |=> rr_interval_value == 24'h000000 && !beat_event_flag
        && second_interrupt_out_n && cnt.count == 14'h0000;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // R05 R14

  property p_value_hold;
    @(posedge ref_clk) disable iff (srst)
      !r_event && !ovf_set && !(ovf_held_q && value_read) |=> $stable(rr_interval_value);
  endproperty
  a_value_hold: assert property (p_value_hold) else $error("result word moved unasked"); // R02

  property p_count_frozen;
    @(posedge ref_clk) disable iff (srst)
      !lsb_tick_en && !r_event |=> $stable(cnt.count);
  endproperty
  a_count_frozen: assert property (p_count_frozen) else $error("count moved, base stopped"); // R03

  property p_count_step;
    @(posedge ref_clk) disable iff (srst)
      !r_event |=> cnt.count == $past(cnt.count)
        || cnt.count == $past(cnt.count) + 14'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped"); // R03

  property p_wrap;
    @(posedge ref_clk) disable iff (srst)
      cnt.overflow |-> cnt.count == 14'h0000 && $past(cnt.count) == 14'h3FFF;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow pulse without wrap"); // R13

  // ---------------------------------------------------------------
  // checks: beat flag and pin
  // ---------------------------------------------------------------
  property p_flag_quiet;
    @(posedge ref_clk) disable iff (srst)
      !beat_event_flag && !r_event && !(cnt.overflow && !beat_flag_clear_mode[1])
      |=> !beat_event_flag;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag rose with no event"); // R05 R13

  property p_flag_hold;
    @(posedge ref_clk) disable iff (srst)
      beat_event_flag
      && !(beat_flag_clear_mode == rr_interval_pkg::CLR_ON_STATUS && status_read)
      && !(beat_flag_clear_mode == rr_interval_pkg::CLR_ON_VALUE && value_read)
      && !(beat_flag_clear_mode[1] && ecg_data_tick)
      |=> beat_event_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped unasked"); // R12

  property p_set_wins;
    @(posedge ref_clk) disable iff (srst)
      r_event && (status_read || value_read || ecg_data_tick)
      |=> beat_event_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event"); // R05

  property p_value_mode_keeps;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode == 2'h1 && beat_event_flag && status_read && !value_read
      |=> beat_event_flag;
  endproperty
  a_value_mode_keeps: assert property (p_value_mode_keeps) else $error("status read cleared"); // R06 R12

  property p_self_mode_keeps;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode[1] && beat_event_flag && !ecg_data_tick |=> beat_event_flag;
  endproperty
  a_self_mode_keeps: assert property (p_self_mode_keeps) else $error("early self clear"); // R08 R12

  property p_status_mode_keeps;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode == 2'h0 && beat_event_flag && ecg_data_tick && !status_read
      |=> beat_event_flag;
  endproperty
  a_status_mode_keeps: assert property (p_status_mode_keeps) else $error("tick cleared"); // R07 R12

  property p_pin_beat;
    @(posedge ref_clk) disable iff (srst)
      r_event |=> !second_interrupt_out_n;
  endproperty
  a_pin_beat: assert property (p_pin_beat) else $error("pin idle after beat"); // R05

  property p_pin_ovf;
    @(posedge ref_clk) disable iff (srst)
      cnt.overflow && !beat_flag_clear_mode[1] |=> !second_interrupt_out_n;
  endproperty
  a_pin_ovf: assert property (p_pin_ovf) else $error("pin idle after overflow"); // R10

  // ---------------------------------------------------------------
  // checks: overflow result
  // ---------------------------------------------------------------
  property p_ovf_held_code;
    @(posedge ref_clk) disable iff (srst)
      ovf_held_q |-> rr_interval_value == 24'hFFFC00;
  endproperty
  a_ovf_held_code: assert property (p_ovf_held_code) else $error("held overflow lost code"); // R10

  property p_ovf_held_drop;
    @(posedge ref_clk) disable iff (srst)
      ovf_held_q && value_read && !r_event && !ovf_set |=> !ovf_held_q;
  endproperty
  a_ovf_held_drop: assert property (p_ovf_held_drop) else $error("overflow kept after read"); // R11

  property p_plain_read_keeps;
    @(posedge ref_clk) disable iff (srst)
      !ovf_held_q && value_read && !r_event && !ovf_set |=> $stable(rr_interval_value);
  endproperty
  a_plain_read_keeps: assert property (p_plain_read_keeps) else $error("read reset result"); // R11

  property p_ind_keeps_value;
    @(posedge ref_clk) disable iff (srst)
      beat_flag_clear_mode[1] && cnt.overflow && !r_event && !(ovf_held_q && value_read)
      |=> $stable(rr_interval_value);
  endproperty
  a_ind_keeps_value: assert property (p_ind_keeps_value) else $error("wrap changed result"); // R13

  property p_beat_drops_held;
    @(posedge ref_clk) disable iff (srst)
      r_event |=> !ovf_held_q;
  endproperty
  a_beat_drops_held: assert property (p_beat_drops_held) else $error("beat kept overflow"); // R02 R11
endmodule
`default_nettype wire

// ### design/rr_interval_pkg.sv
// constants for the r-to-r interval timer
package rr_interval_pkg;
  localparam int unsigned INTERVAL_BITS  = 14;
  localparam int unsigned WORD_BITS      = 24;
  localparam int unsigned INTERVAL_SHIFT = 10;
  localparam logic [13:0] OVERFLOW_CODE  = 14'h3FFF;
  localparam logic [23:0] VALUE_RESET    = 24'h000000;
  // beat_flag_clear_mode encodings
  localparam logic [1:0]  CLR_ON_STATUS  = 2'h0;
  localparam logic [1:0]  CLR_ON_VALUE   = 2'h1;
  localparam logic [1:0]  CLR_SELF       = 2'h2;
  localparam int unsigned MODE_IND_BIT   = 1;
  // interval lsb time and its cycle count at ref_clk
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned LSB_TIME_US    = 8000;
  localparam int unsigned LSB_CYCLES     = (LSB_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
endpackage

// ### design/rr_count_if.sv
// link between the interval counter and the result logic
`timescale 1ns/1ps
`default_nettype none
interface rr_count_if #(parameter int unsigned W = 14);
  logic [W-1:0] count;    // running interval count
  logic         overflow; // one-cycle pulse on wrap
  logic         restart;  // clear count to zero
  modport counter  (output count, output overflow, input restart);
  modport consumer (input count, input overflow, output restart);
endinterface
`default_nettype wire

// ### design/rr_interval_counter.sv
// prescaled interval counter with wrap pulse
`timescale 1ns/1ps
`default_nettype none
module rr_interval_counter #(
  parameter int unsigned W          = 14,
  parameter int unsigned LSB_CYCLES = rr_interval_pkg::LSB_CYCLES
) (
  input  wire logic    ref_clk,  // 200 MHz clock
  input  wire logic    srst,     // sync reset, high
  input  wire logic    lsb_tick_en, // run prescaler
  rr_count_if.counter  cnt       // count, wrap, restart
);
  logic [31:0]  pre_q, pre_d;
  logic [W-1:0] count_q, count_d;
  logic         ovf_q, ovf_d;
  logic         tick;

  always_comb begin
    tick    = lsb_tick_en && (pre_q == LSB_CYCLES - 1);
    pre_d   = tick ? 32'h0 : (lsb_tick_en ? pre_q + 32'h1 : pre_q);
    count_d = count_q;
    ovf_d   = 1'b0;
    if (cnt.restart) begin
      // restart also realigns the prescaler so each beat starts a full lsb
      count_d = '0; // R14
      pre_d   = 32'h0;
    end else if (tick) begin
      count_d = count_q + W'(1); // R03
      ovf_d   = (count_q == {W{1'b1}});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_q   <= 32'h0;
      count_q <= '0;
      ovf_q   <= 1'b0;
    end else begin
      pre_q   <= pre_d;
      count_q <= count_d;
      ovf_q   <= ovf_d;
    end
  end

  assign cnt.count    = count_q;
  assign cnt.overflow = ovf_q;
endmodule
`default_nettype wire

// ### verification/rr_host_model.sv
// host model that sets the clear mode and issues read strobes
`timescale 1ns/1ps
`default_nettype none
module rr_host_model (
  input  wire logic        ref_clk,              // bench clock
  input  wire logic [23:0] rr_interval_value,    // result word seen
  input  wire logic        beat_event_flag,      // status bit seen
  output var  logic [1:0]  beat_flag_clear_mode, // clear mode setting
  output var  logic        value_read,           // result read strobe
  output var  logic        status_read           // status read strobe
);
  initial begin
    beat_flag_clear_mode = 2'h0;
    value_read           = 1'b0;
    status_read          = 1'b0;
  end
  // self clear is picked while the host also reads the result and status words
  task automatic set_mode(input logic [1:0] m);
    @(posedge ref_clk);
    #1 beat_flag_clear_mode = m;
  endtask
  // data taken as the strobe rises, before any read side effect lands
  task automatic read_value(output logic [23:0] v);
    @(posedge ref_clk);
    #1 v = rr_interval_value;
    value_read = 1'b1;
    @(posedge ref_clk);
    #1 value_read = 1'b0;
  endtask
  task automatic read_status(output logic f);
    @(posedge ref_clk);
    #1 f = beat_event_flag;
    status_read = 1'b1;
    @(posedge ref_clk);
    #1 status_read = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/rr_interval_timer_bench.sv
// self-checking bench for the r-to-r interval timer
`timescale 1ns/1ps
`default_nettype none
module rr_interval_timer_bench;
  // short prescale keeps each overflow near 33k cycles
  localparam int unsigned LSB      = 2;
  localparam int          OVF_WAIT = 16384 * LSB + 64;
  logic        ref_clk = 1'b0, srst = 1'b1, r_event = 1'b0, ecg_data_tick = 1'b0;
  logic        lsb_tick_en = 1'b0, value_read, status_read, flag, pin_n, f, hit;
  logic [1:0]  mode;
  logic [23:0] value, a, b;
  int          failures = 0, samples_checked = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  rr_interval_timer #(.LSB_CYCLES(LSB)) i_dut (.ref_clk(ref_clk), .srst(srst),
    .r_event(r_event), .ecg_data_tick(ecg_data_tick), .lsb_tick_en(lsb_tick_en),
    .beat_flag_clear_mode(mode), .value_read(value_read), .status_read(status_read),
    .rr_interval_value(value), .beat_event_flag(flag), .second_interrupt_out_n(pin_n));
  rr_host_model i_host (.ref_clk(ref_clk), .rr_interval_value(value),
    .beat_event_flag(flag), .beat_flag_clear_mode(mode), .value_read(value_read),
    .status_read(status_read));
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse_r;
    @(posedge ref_clk);
    #1 r_event = 1'b1;
    @(posedge ref_clk);
    #1 r_event = 1'b0;
  endtask
  task automatic pulse_ecg;
    @(posedge ref_clk);
    #1 ecg_data_tick = 1'b1;
    @(posedge ref_clk);
    #1 ecg_data_tick = 1'b0;
  endtask
  initial begin
    tick(2);
    srst = 1'b0;
    check("value after reset", value, 24'h000000);
    check("pin after reset", 24'(pin_n), 24'h000001);
    // timing base stopped: the interval must read zero
    pulse_r();
    tick(30);
    pulse_r();
    i_host.read_value(a);
    check("value with base stopped", a, 24'h000000);
    // the first read adds 2 cycles to the 18 extra, so 20 extra cycles separate the two results
    lsb_tick_en = 1'b1;
    tick(22);
    pulse_r();
    i_host.read_value(a);
    tick(40);
    pulse_r();
    i_host.read_value(b);
    check("low bits zero", 24'(b[9:0]), 24'h000000);
    check("interval step", 24'(b[23:10] - a[23:10]), 24'h00000A);
    $display("test interval done");
    for (int m = 0; m < 4; m++) begin
      i_host.set_mode(2'(m));
      pulse_r();
      check("flag set", 24'(flag), 24'h000001);
      check("pin low", 24'(pin_n), 24'h000000);
      if (m != 1) i_host.read_value(a);
      if (m != 0) i_host.read_status(f);
      if (m < 2) pulse_ecg();
      tick(1);
      check("flag kept", 24'(flag), 24'h000001);
      case (m)
        0: i_host.read_status(f);
        1: i_host.read_value(a);
        default: pulse_ecg();
      endcase
      tick(1);
      check("flag cleared", 24'(flag), 24'h000000);
      check("pin released", 24'(pin_n), 24'h000001);
    end
    i_host.set_mode(2'h0);
    fork
      pulse_r();
      i_host.read_status(f);
    join
    check("set beats clear", 24'(flag), 24'h000001);
    i_host.read_status(f);
    $display("test clear modes done");
    for (n = 0; n < OVF_WAIT && flag !== 1'b1; n++) tick(1);
    // a missed overflow counts once and skips straight to the report
    if (flag !== 1'b1) begin
      failures++;
    end else begin
      check("overflow code", value, 24'hFFFC00);
      i_host.read_value(a);
      tick(1);
      check("overflow reset", value, 24'h000000);
      check("flag apart", 24'(flag), 24'h000001);
      i_host.read_status(f);
      $display("test overflow done");
      i_host.set_mode(2'h2);
      pulse_r();
      pulse_ecg();
      i_host.read_value(b);
      hit = 1'b0;
      for (n = 0; n < OVF_WAIT; n++) begin
        tick(1);
        if (flag !== 1'b0) hit = 1'b1;
      end
      check("wrap no flag", 24'(hit), 24'h000000);
      check("wrap no code", value, b);
      // 32837 base edges at two per step: 16418 steps, one wrap leaves 34
      pulse_r();
      check("count after wrap", value, 24'h008800);
      $display("test wrap done");
      // second reset with flag set and a nonzero result
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      check("value after second reset", value, 24'h000000);
      check("flag after second reset", 24'(flag), 24'h000000);
      check("pin after second reset", 24'(pin_n), 24'h000001);
      $display("test reset done");
    end
    summarize();
  end
endmodule
`default_nettype wire
